// file: verilog/rdq_pkg.sv
`default_nettype none
// ************************************************************
// Shared constants of the receive data qualifier
// ************************************************************
package rdq_pkg;
   // Register byte addresses
   localparam logic [7:0] RDQ_ADDR_CTRL   = 8'h00; // Receive control word
   localparam logic [7:0] RDQ_ADDR_RATE   = 8'h04; // Rate setting word
   localparam logic [7:0] RDQ_ADDR_THRESH = 8'h08; // Quality and strength threshold word
   localparam logic [7:0] RDQ_ADDR_SYNC   = 8'h0c; // Programmable sync byte word
   localparam logic [7:0] RDQ_ADDR_STATUS = 8'h10; // Status word, read only
   // Control word fields
   localparam int RDQ_C_RXEN  = 0; // Receiver enabled
   localparam int RDQ_C_DIG   = 1; // Digital filtering selected
   localparam int RDQ_C_FIFO  = 2; // Receive fifo in use
   localparam int RDQ_C_VDEN  = 3; // Valid data indicator enabled
   localparam int RDQ_C_RESP  = 4; // Response mode, two bits
   localparam int RDQ_C_CRM   = 6; // Clock recovery mode, two bits
   localparam int RDQ_C_WORD  = 8; // Word length sync pattern
   localparam int RDQ_C_TX    = 9; // Transmit mode
   localparam int RDQ_C_W     = 10;
   // Rate word fields
   localparam int RDQ_R_PRE   = 8; // Prescaler enable
   localparam int RDQ_R_W     = 9;
   // Status word fields
   localparam int RDQ_S_QOK   = 7; // Quality ok bit
   localparam int RDQ_S_ANT   = 8; // Antenna strength bit
   // Reset values
   localparam logic [RDQ_C_W-1:0] RDQ_CTRL_RST = 10'h000;
   localparam logic [RDQ_R_W-1:0] RDQ_RATE_RST = 9'h000;
   localparam logic [7:0]         RDQ_SYNC_RST = 8'hd4;
   localparam logic [5:0]         RDQ_THR_RST  = 6'h05;
   // Fixed upper sync byte
   localparam logic [7:0] RDQ_SYNC_HIGH = 8'h2d;
   // Filter ticks per data bit and prescale factor
   localparam logic [4:0] RDQ_BIT_TICKS = 5'd29;
   localparam logic [4:0] RDQ_HALF_BIT  = 5'd14;
   localparam logic [6:0] RDQ_PRESCALE  = 7'd64;
   // Quality measure and lock figures
   localparam logic [2:0] RDQ_Q_MAX      = 3'd7;
   localparam logic [2:0] RDQ_GOOD_BITS  = 3'd5;
   localparam logic [3:0] RDQ_RUN_MAX    = 4'd8;
   localparam logic [4:0] RDQ_LOCK_WIN   = 5'd3;
   localparam logic [2:0] RDQ_LOCK_EDGES = 3'd4;
   localparam logic [2:0] RDQ_STR_RSVD   = 3'd6;
   // Valid indicator response modes
   typedef enum logic [1:0] {
      RDQ_RESP_DEFAULT = 2'b00,
      RDQ_RESP_SLOW    = 2'b01,
      RDQ_RESP_MEDIUM  = 2'b10,
      RDQ_RESP_FAST    = 2'b11
   } rdq_resp_type;
   // Clock recovery modes
   typedef enum logic [1:0] {
      RDQ_CR_AUTO = 2'b00,
      RDQ_CR_FAST = 2'b01,
      RDQ_CR_SLOW = 2'b10
   } rdq_cr_type;
endpackage : rdq_pkg
`default_nettype wire

// file: verilog/rdq_qualifier.sv
// What this block does
// [R1] Digital filter ticks at 29 times data rate
// [R2] Recovered clock loads fifo or drives pin
// [R3] Analog mode bypasses fifo, no recovered clock
// [R4] Rate divider with optional prescaler
// [R5] Clock recovery slow, fast and automatic modes
// [R6] Quality high after five good bits
// [R7] Quality indicator works only while receiving
// [R8] Host keeps quality threshold at most seven
// [R9] Indicator disabled passes raw comparator data
// [R10] Default mode holds indicator high
// [R11] Slow mode: set all three, clear none
// [R12] Medium mode: lock and strength or quality
// [R13] Fast mode tracks quality indicator
// [R14] Indicator usable with fifo and on pin
// [R15] Sync pattern: fixed high, programmable low
// [R16] Byte or word length sync match
// [R17] Strength flag set above programmed threshold
// [R18] Threshold codes six and seven reserved
// [R19] Strength result gates quality ok bit
// [R20] Bit eight: antenna or strength by mode
// [R21] Configuration takes effect next clock
`timescale 1ns/1ps
`default_nettype none
module rdq_qualifier (
   // Clock and reset
   input  wire logic                 MCLK_I,
   input  wire logic                 SYS_RST_I,
   // Apb slave
   input  wire logic                 PSEL_I,
   input  wire logic                 PENABLE_I,
   input  wire logic                 PWRITE_I,
   input  wire logic [7:0]           PADDR_I,
   input  wire logic [31:0]          PWDATA_I,
   output logic      [31:0]          PRDATA_O,
   output logic                      PREADY_O,
   output logic                      PSLVERR_O,
   // Receive front end
   input  wire logic                 DEMOD_I,
   input  wire logic [2:0]           STRENGTH_LEVEL_I,
   input  wire logic                 ANT_STRONG_I,
   // Data and indicators
   output logic                      RX_DATA_O,
   output logic                      RECOVERED_CLOCK_PIN_O,
   output logic                      FIFO_LOAD_O,
   output logic                      FIFO_BIT_O,
   output logic                      VALID_DATA_INDICATOR_O,
   output logic                      QUALITY_INDICATOR_O,
   output logic                      SYNC_FOUND_O
);
   import rdq_pkg::*;

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic [RDQ_C_W-1:0] ctrl;             // Receive control word
   logic [RDQ_R_W-1:0] rate;             // Rate setting word
   logic [5:0]         thresh;           // Quality and strength thresholds
   logic [7:0]         sync_low_byte;    // Programmable sync byte
   wire  rx_en   = ctrl[RDQ_C_RXEN];
   wire  dig     = ctrl[RDQ_C_DIG];
   wire  fifo_en = ctrl[RDQ_C_FIFO];
   wire  vd_en   = ctrl[RDQ_C_VDEN];
   wire  rdq_resp_type resp = rdq_resp_type'(ctrl[RDQ_C_RESP +: 2]);
   wire  rdq_cr_type   crm  = rdq_cr_type'(ctrl[RDQ_C_CRM +: 2]);
   wire  [2:0] quality_threshold      = thresh[2:0];
   wire  [2:0] strength_threshold_sel = thresh[5:3];

   // Apb decode
   wire  setup   = PSEL_I & ~PENABLE_I;
   wire  wr_acc  = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
   wire  hit_c   = (PADDR_I == RDQ_ADDR_CTRL);
   wire  hit_r   = (PADDR_I == RDQ_ADDR_RATE);
   wire  hit_t   = (PADDR_I == RDQ_ADDR_THRESH);
   wire  hit_y   = (PADDR_I == RDQ_ADDR_SYNC);
   wire  hit_s   = (PADDR_I == RDQ_ADDR_STATUS);
   wire  mapped  = hit_c | hit_r | hit_t | hit_y | hit_s;
   // Status is read only, a write to it is an error
   wire  bad     = ~mapped | (hit_s & PWRITE_I);

   // ************************************************************
   // Strength comparator and status word
   // ************************************************************
   logic strength_flag;                  // Digital strength result
   logic sync_found;                     // Sync pattern seen
   logic quality_indicator;              // Quality state
   logic recovery_lock;                  // Clock recovery lock
   logic valid_ind;                      // Valid data indicator state
   // Reserved codes never report a signal above threshold
   wire  str_hit = (strength_threshold_sel < RDQ_STR_RSVD) &
                   (STRENGTH_LEVEL_I > strength_threshold_sel); // [R17] [R18]
   wire  quality_ok_bit      = quality_indicator & strength_flag; // [R19]
   wire  antenna_strength_bit = ctrl[RDQ_C_TX] ? ANT_STRONG_I
                                               : strength_flag; // [R20]
   wire  [31:0] status_word = {17'h00000, valid_ind, sync_found,
                               recovery_lock, strength_threshold_sel,
                               antenna_strength_bit, quality_ok_bit,
                               quality_indicator, strength_flag, 5'h00};
   wire  [31:0] rd_mux = hit_c ? {22'h000000, ctrl} :
                         hit_r ? {23'h000000, rate} :
                         hit_t ? {26'h0000000, thresh} :
                         hit_y ? {24'h000000, sync_low_byte} :
                         hit_s ? status_word : 32'h00000000;

   // Bus answer one cycle after setup, no wait states
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end else begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup & bad;
         PRDATA_O  <= (setup & ~PWRITE_I) ? rd_mux : 32'h00000000;
      end
   end

   // Register writes land at the access edge, used from the next clock
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ctrl          <= RDQ_CTRL_RST;
         rate          <= RDQ_RATE_RST;
         thresh        <= RDQ_THR_RST;
         sync_low_byte <= RDQ_SYNC_RST;
      end else if (wr_acc) begin // [R21]
         if (hit_c) ctrl <= PWDATA_I[RDQ_C_W-1:0];
         else if (hit_r) rate <= PWDATA_I[RDQ_R_W-1:0]; // [R4]
         else if (hit_t) thresh <= PWDATA_I[5:0];
         else if (hit_y) sync_low_byte <= PWDATA_I[7:0]; // [R15]
      end
   end

   // ************************************************************
   // Filter tick generator
   // ************************************************************
   logic [13:0] div_cnt;                 // Clocks until next tick
   logic        tick;                    // One pulse per filter period
   // Prescaler stretches the period 64 times for low rates
   wire  [13:0] div_load = rate[RDQ_R_PRE] ?
                           14'((rate[7:0] + 14'd1) * RDQ_PRESCALE) - 14'd1 :
                           14'(rate[7:0]);
   wire  run_dig = rx_en & dig;

   // Tick rate is 29 times the data rate
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !run_dig) begin
         div_cnt <= 14'h0000;
         tick    <= 1'b0;
      end else if (div_cnt == 14'h0000) begin // [R1]
         div_cnt <= div_load;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt - 14'd1;
         tick    <= 1'b0;
      end
   end

   // ************************************************************
   // Clock recovery
   // ************************************************************
   logic       d_q;                      // Data at last tick
   logic [4:0] phase;                    // Position inside a bit
   logic [2:0] lock_cnt;                 // Aligned edges seen
   wire  edge_seen = tick & (DEMOD_I != d_q);
   wire  near_zero = (phase <= RDQ_LOCK_WIN) |
                     (phase >= RDQ_BIT_TICKS - RDQ_LOCK_WIN);
   // Auto mode settles fast, then holds steady once locked
   wire  fast_cr   = (crm == RDQ_CR_FAST) |
                     ((crm == RDQ_CR_AUTO) & ~recovery_lock); // [R5]
   wire  [4:0] ph_inc = (phase == RDQ_BIT_TICKS - 5'd1) ? 5'd0 : phase + 5'd1;
   // Slow mode nudges one step per edge: better noise immunity
   wire  [4:0] ph_slow = (phase == 5'd0) ? 5'd1 :
                         (phase <= RDQ_HALF_BIT) ? phase :
                         (ph_inc == RDQ_BIT_TICKS - 5'd1) ? 5'd0 :
                         (ph_inc == 5'd0) ? 5'd1 : ph_inc + 5'd1;
   wire  sample = tick & (phase == RDQ_HALF_BIT);

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !run_dig) begin
         d_q      <= 1'b0;
         phase    <= 5'd0;
         lock_cnt <= 3'd0;
         recovery_lock <= 1'b0;
      end else if (tick) begin
         d_q <= DEMOD_I;
         if (edge_seen) begin
            phase <= fast_cr ? 5'd1 : ph_slow; // [R5]
            if (!near_zero) begin
               lock_cnt      <= 3'd0;
               recovery_lock <= 1'b0;
            end else if (lock_cnt == RDQ_LOCK_EDGES) begin
               recovery_lock <= 1'b1;
            end else begin
               lock_cnt <= lock_cnt + 3'd1;
            end
         end else begin
            phase <= ph_inc;
         end
      end
   end

   // ************************************************************
   // Data quality indicator
   // ************************************************************
   logic [4:0] sub;                      // Ticks into current bit
   logic [3:0] nb;                       // Whole bits in current run
   logic [2:0] good_bits;                // Good bits in a row
   logic       seen_hi;                  // A good high run seen
   logic       seen_lo;                  // A good low run seen
   // Timing error of a run end against the bit grid
   wire  [4:0] err   = (sub <= RDQ_HALF_BIT) ? sub : RDQ_BIT_TICKS - sub;
   wire  [3:0] bits  = (sub <= RDQ_HALF_BIT) ? nb : nb + 4'd1;
   wire  [2:0] qval  = (err >= 5'(RDQ_Q_MAX)) ? 3'd0 : RDQ_Q_MAX - err[2:0];
   wire  run_good    = (bits != 4'd0) & (bits <= RDQ_RUN_MAX) &
                       (qval > quality_threshold); // [R8]
   wire  [3:0] gsum  = 4'(good_bits) + bits;
   wire  run_long    = (nb > RDQ_RUN_MAX);

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !run_dig) begin // [R7]
         sub <= 5'd0;
         nb  <= 4'd0;
         good_bits <= 3'd0;
         seen_hi   <= 1'b0;
         seen_lo   <= 1'b0;
         quality_indicator <= 1'b0;
      end else if (edge_seen) begin
         sub <= 5'd0;
         nb  <= 4'd0;
         if (run_good) begin
            good_bits <= (gsum >= 4'(RDQ_GOOD_BITS)) ? RDQ_GOOD_BITS : gsum[2:0];
            seen_hi   <= seen_hi | d_q;
            seen_lo   <= seen_lo | ~d_q;
            // Both polarities must have passed before the flag rises
            if (gsum >= 4'(RDQ_GOOD_BITS) && (seen_hi | d_q) && (seen_lo | ~d_q))
               quality_indicator <= 1'b1; // [R6]
         end else begin
            good_bits <= 3'd0;
            seen_hi   <= 1'b0;
            seen_lo   <= 1'b0;
            quality_indicator <= 1'b0;
         end
      end else if (tick) begin
         if (sub == RDQ_BIT_TICKS - 5'd1) begin
            sub <= 5'd0;
            if (!run_long) nb <= nb + 4'd1;
         end else begin
            sub <= sub + 5'd1;
         end
         // A stuck line is no longer a valid signal
         if (run_long) begin
            good_bits <= 3'd0;
            quality_indicator <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Valid data indicator and strength flag
   // ************************************************************
   wire  qual_any  = strength_flag | quality_indicator;
   wire  all_three = strength_flag & quality_indicator & recovery_lock;
   wire  none_hi   = ~strength_flag & ~quality_indicator & ~recovery_lock;
   logic next_valid;                     // Indicator for next clock
   always_comb begin
      next_valid = valid_ind;
      case (resp)
         RDQ_RESP_DEFAULT: next_valid = 1'b1; // [R10]
         RDQ_RESP_SLOW: begin
            if (all_three) next_valid = 1'b1; // [R11]
            else if (none_hi) next_valid = 1'b0;
         end
         RDQ_RESP_MEDIUM: next_valid = recovery_lock & qual_any; // [R12]
         RDQ_RESP_FAST:   next_valid = quality_indicator; // [R13]
         default:         next_valid = 1'b1;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         valid_ind     <= 1'b1;
         strength_flag <= 1'b0;
      end else begin
         valid_ind     <= next_valid;
         strength_flag <= rx_en & str_hit; // [R17]
      end
   end

   // ************************************************************
   // Sync pattern matcher
   // ************************************************************
   logic [15:0] shreg;                   // Last sixteen sampled bits
   wire  [15:0] shn   = {shreg[14:0], DEMOD_I};
   wire  byte_hit     = (shn[7:0] == sync_low_byte);
   wire  word_hit     = (shn == {RDQ_SYNC_HIGH, sync_low_byte});
   wire  pat_hit      = ctrl[RDQ_C_WORD] ? word_hit : byte_hit; // [R16]

   // Found flag is sticky until the receiver is switched off or set to analog mode
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !run_dig) begin
         shreg      <= 16'h0000;
         sync_found <= 1'b0;
      end else if (sample) begin
         shreg <= shn;
         if (pat_hit) sync_found <= 1'b1; // [R15]
      end
   end

   // ************************************************************
   // Output stage
   // ************************************************************
   // Raw comparator data when the indicator is off, else gated
   wire  data_q  = vd_en ? (DEMOD_I & valid_ind) : DEMOD_I; // [R9]
   wire  rec_clk = (phase > RDQ_HALF_BIT);
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         RX_DATA_O              <= 1'b0;
         RECOVERED_CLOCK_PIN_O  <= 1'b0;
         FIFO_LOAD_O            <= 1'b0;
         FIFO_BIT_O             <= 1'b0;
         VALID_DATA_INDICATOR_O <= 1'b1;
         QUALITY_INDICATOR_O    <= 1'b0;
         SYNC_FOUND_O           <= 1'b0;
      end else begin
         RX_DATA_O <= rx_en & data_q; // [R3]
         // Pin shows the recovered clock only when the fifo is idle
         RECOVERED_CLOCK_PIN_O <= run_dig & ~fifo_en & rec_clk; // [R2] [R3]
         FIFO_LOAD_O <= sample & fifo_en & (~vd_en | valid_ind); // [R2] [R9]
         FIFO_BIT_O  <= sample ? DEMOD_I : FIFO_BIT_O;
         VALID_DATA_INDICATOR_O <= next_valid; // [R14]
         QUALITY_INDICATOR_O    <= quality_indicator;
         SYNC_FOUND_O           <= sync_found;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence s_access;
      PSEL_I && PENABLE_I;
   endsequence
   property p_ready;
      @(posedge MCLK_I) disable iff (SYS_RST_I) s_setup |=> PREADY_O;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup"); // [R21]
   property p_default;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         resp == RDQ_RESP_DEFAULT |=> VALID_DATA_INDICATOR_O;
   endproperty
   a_default: assert property (p_default) else $error("default not high"); // [R10]
   property p_fast;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         resp == RDQ_RESP_FAST |=> valid_ind == $past(quality_indicator);
   endproperty
   a_fast: assert property (p_fast) else $error("fast not tracking"); // [R13]
   property p_medium;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         resp == RDQ_RESP_MEDIUM && !recovery_lock |=> !valid_ind;
   endproperty
   a_medium: assert property (p_medium) else $error("medium without lock"); // [R12]
   property p_slow_hold;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         resp == RDQ_RESP_SLOW && valid_ind && !none_hi |=> valid_ind;
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("slow dropped early"); // [R11]
   property p_qi_off;
      @(posedge MCLK_I) disable iff (SYS_RST_I) !rx_en |=> !quality_indicator;
   endproperty
   a_qi_off: assert property (p_qi_off) else $error("quality while off"); // [R7]
   property p_qok;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         status_word[RDQ_S_QOK] |-> strength_flag && quality_indicator;
   endproperty
   a_qok: assert property (p_qok) else $error("quality ok ungated"); // [R19]
   property p_analog;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         !dig ##1 !dig |-> !RECOVERED_CLOCK_PIN_O && !FIFO_LOAD_O;
   endproperty
   a_analog: assert property (p_analog) else $error("clock in analog mode"); // [R3]
   property p_tick;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         tick && !rate[RDQ_R_PRE] && rate[7:0] != 8'h00 && $stable(rate) && run_dig |=> !tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too dense"); // [R1]
   property p_reserved;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
         strength_threshold_sel >= RDQ_STR_RSVD ##1 $stable(thresh) |-> !strength_flag;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code hit"); // [R18]
endmodule : rdq_qualifier
`default_nettype wire

// file: tb/rdq_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Front end model: demodulated bit source
// ********************************************
module rdq_fe_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Stream control
   input  wire logic        run_i,
   input  wire logic [15:0] pat_i,
   // Demodulated data
   output logic             demod_o
);
   logic [4:0]  tick; // Clocks into current bit
   logic [4:0]  idx;  // Bit of the frame, msb first
   logic [31:0] frm;  // Preamble then pattern word
   assign frm = {16'haaaa, pat_i};
   // 29 clocks a bit; when stopped the line is noise, not a held level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick    <= 5'h00;
         idx     <= 5'h00;
         demod_o <= 1'b0;
      end else if (!run_i) begin
         tick    <= 5'h00;
         demod_o <= ~demod_o;
      end else if (tick == 5'h1c) begin
         tick    <= 5'h00;
         idx     <= idx + 5'h01;
         demod_o <= frm[~idx];
      end else begin
         tick <= tick + 5'h01;
      end
   end
endmodule : rdq_fe_model
`default_nettype wire

// file: tb/rdq_qualifier_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Bench for the receive data qualifier
// ********************************************
module rdq_qualifier_tb_top;
   import rdq_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} rdq_exp_type;
   logic        mclk = 1'b0;                         // Bench clock
   logic        rst  = 1'b1;                         // Held 8 cycles
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0; // Apb request
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd  = 32'h0;
   logic        run  = 1'b0, ant = 1'b0;             // Front end stimulus
   logic [2:0]  lvl  = 3'h0;
   logic [15:0] pat  = 16'haaaa;
   logic [31:0] prd;
   logic        prdy, perr, dmd, rxd, rck, fld, fbt, vdi, qin, syf;
   int          n_errors = 0, cmp_count = 0, nr, nl;
   rdq_exp_type expq[$], x;                          // Transfer notes, oldest first
   always #5 mclk = ~mclk;
   rdq_fe_model fe (.clk_i(mclk), .rst_i(rst), .run_i(run), .pat_i(pat), .demod_o(dmd));
   rdq_qualifier dut (.MCLK_I(mclk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .DEMOD_I(dmd), .STRENGTH_LEVEL_I(lvl), .ANT_STRONG_I(ant),
      .RX_DATA_O(rxd), .RECOVERED_CLOCK_PIN_O(rck), .FIFO_LOAD_O(fld), .FIFO_BIT_O(fbt),
      .VALID_DATA_INDICATOR_O(vdi), .QUALITY_INDICATOR_O(qin), .SYNC_FOUND_O(syf));
   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   // One transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic er);
      int k;
      expq.push_back('{d, w ? 32'h0 : m, er});
      @(posedge mclk);
      psel <= 1'b1;
      pwr  <= w;
      padr <= a;
      pwd  <= d;
      @(posedge mclk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (prdy !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk_bit("pready", 1'b1, prdy);
         conclude();
      end
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   // Bounded wait for a level, a run out bound ends the run
   task automatic wait_lvl(input string nm, ref logic s, input logic v, input int lim);
      int k;
      for (k = 0; k < lim && s !== v; k++) @(posedge mclk);
      chk_bit(nm, v, s);
      if (k == lim) conclude();
   endtask : wait_lvl
   // Answer watcher: compares each completed transfer with its note
   always @(posedge mclk) begin
      if (psel && pen && prdy === 1'b1) begin
         x = expq.pop_front();
         chk_word("prdata", x.v & x.m, prd & x.m);
         chk_bit("pslverr", x.e, perr);
      end
   end
   initial begin
      void'($urandom(32'h2081));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk_bit("indicator reset", 1'b1, vdi);
      apb(0, RDQ_ADDR_CTRL, 32'h0, '1, 0);
      apb(0, RDQ_ADDR_THRESH, 32'h5, '1, 0);
      apb(0, RDQ_ADDR_SYNC, 32'hd4, '1, 0);
      apb(1, RDQ_ADDR_RATE, '1, '0, 0);
      apb(0, RDQ_ADDR_RATE, 32'h1ff, '1, 0);
      apb(1, RDQ_ADDR_RATE, 32'h0, '0, 0);
      apb(0, 8'h14, 32'h0, '1, 1);
      apb(1, RDQ_ADDR_STATUS, 32'h3f, '0, 1);
      // Strength compare over every threshold code, boundary level first
      apb(1, RDQ_ADDR_CTRL, 32'h1, '0, 0);
      for (int s = 0; s < 8; s++) begin
         apb(1, RDQ_ADDR_THRESH, {26'h0, s[2:0], 3'h5}, '0, 0);
         for (int k = 0; k < 2; k++) begin
            lvl <= (k == 0) ? 3'(s + 1) : 3'($urandom);
            repeat (3) @(posedge mclk);
            nr = (s < 6 && lvl > s) ? 32'h120 : 32'h0;
            apb(0, RDQ_ADDR_STATUS, nr | (s << 9), 32'hf20, 0);
         end
      end
      apb(1, RDQ_ADDR_CTRL, 32'h200, '0, 0);
      for (int b = 0; b < 2; b++) begin
         ant <= b[0];
         repeat (3) @(posedge mclk);
         apb(0, RDQ_ADDR_STATUS, 32'(b) << 8, 32'h100, 0);
      end
      // Analog, digital without fifo, digital with fifo
      run <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         apb(1, RDQ_ADDR_CTRL, (m == 0) ? 32'h9 : (m == 1) ? 32'hb : 32'hf, '0, 0);
         nr = 0;
         nl = 0;
         // Skip the edge that still shows the old mode
         @(posedge mclk);
         repeat (290) begin
            @(posedge mclk);
            nr += (rck === 1'b1);
            nl += (fld === 1'b1);
         end
         chk_bit("recovered clock", m == 1, nr > 0);
         chk_bit("fifo load", m == 2, nl >= 8);
      end
      apb(1, RDQ_ADDR_CTRL, 32'h0, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("quality rx off", 1'b0, qin);
      // Response modes; strength kept off with a reserved code
      apb(1, RDQ_ADDR_THRESH, 32'h3d, '0, 0);
      apb(1, RDQ_ADDR_CTRL, 32'h1b, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("slow clear", 1'b0, vdi);
      chk_bit("rx data gated", 1'b0, rxd);
      repeat (110) @(posedge mclk);
      chk_bit("quality early", 1'b0, qin);
      wait_lvl("quality", qin, 1'b1, 600);
      repeat (60) @(posedge mclk);
      chk_bit("slow needs all", 1'b0, vdi);
      apb(0, RDQ_ADDR_STATUS, 32'h40, 32'he0, 0);
      apb(1, RDQ_ADDR_CTRL, 32'h2b, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("medium", 1'b1, vdi);
      apb(1, RDQ_ADDR_THRESH, 32'h05, '0, 0);
      lvl <= 3'h7;
      apb(0, RDQ_ADDR_STATUS, 32'he0, 32'he0, 0);
      apb(1, RDQ_ADDR_CTRL, 32'h1b, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("slow set", 1'b1, vdi);
      run <= 1'b0;
      wait_lvl("quality noise", qin, 1'b0, 600);
      chk_bit("slow hold", 1'b1, vdi);
      apb(1, RDQ_ADDR_CTRL, 32'h3b, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("fast", 1'b0, vdi);
      apb(1, RDQ_ADDR_CTRL, 32'h0b, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("default", 1'b1, vdi);
      // Sync word, then a word with only the low byte right
      pat <= 16'h2dd4;
      run <= 1'b1;
      apb(1, RDQ_ADDR_CTRL, 32'h10b, '0, 0);
      wait_lvl("sync word", syf, 1'b1, 2000);
      pat <= 16'h33d4;
      apb(1, RDQ_ADDR_CTRL, 32'h0, '0, 0);
      repeat (3) @(posedge mclk);
      chk_bit("sync cleared", 1'b0, syf);
      apb(1, RDQ_ADDR_CTRL, 32'h10b, '0, 0);
      repeat (2000) @(posedge mclk);
      chk_bit("sync high byte", 1'b0, syf);
      apb(1, RDQ_ADDR_CTRL, 32'h0b, '0, 0);
      wait_lvl("sync byte", syf, 1'b1, 2000);
      conclude();
   end
endmodule : rdq_qualifier_tb_top
`default_nettype wire
